// *** logic/dual_slope_pkg.sv ***
/*
 phase codes, timing constants and user-side structs for the dual-slope
 phase sequencer. assumes a 50 MHz controller clock.
*/
`default_nettype none
package dual_slope_pkg;
   localparam int unsigned CLOCK_HZ = 50_000_000;
   // offset null time in microseconds
   localparam int unsigned NULL_TIME_US = 20;
   localparam int unsigned NULL_CYCLES_I = (NULL_TIME_US * (CLOCK_HZ / 1_000_000));
   localparam int unsigned COUNT_W = 24;
   localparam logic [COUNT_W-1:0] NULL_CYCLES = NULL_CYCLES_I[COUNT_W-1:0];
   // accumulate period in cycles; a line period multiple gives hum rejection
   localparam logic [COUNT_W-1:0] ACCUM_CYCLES = 24'h000_fa0;
   // rundown bound: twice the accumulate period
   localparam logic [COUNT_W-1:0] RUNDOWN_MAX = 24'h001_f40;
   localparam logic [COUNT_W-1:0] ZERO_MAX = 24'h000_3e8;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h00_0001;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h00_0000;

   // step line codes {first, second}
   localparam logic [1:0] STEP_NULL = 2'h1;
   localparam logic [1:0] STEP_ACCUM = 2'h2;
   localparam logic [1:0] STEP_RUNDOWN = 2'h3;
   localparam logic [1:0] STEP_ZERO = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE, ST_NULL, ST_ACCUM, ST_RUNDOWN, ST_ZERO
   } phase_t;

   typedef struct packed {
      logic [1:0]  channel;
      logic        use_zero;
   } request_t;

   typedef struct packed {
      logic [COUNT_W-1:0] rundown_period;
      logic               positive;
      logic               overrange;
      logic [1:0]         channel;
   } result_t;
endpackage
`default_nettype wire

// *** logic/dual_slope_phase_sequencer.sv ***
/*
 controller that steps a dual-slope converter front end through its four
 phases, drives the channel select lines and times the rundown phase.
 assumes comparator_out arrives asynchronously from the converter pins.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_slope_phase_sequencer
(
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   input  wire logic                        enable,
   input  wire logic                        start,
   input  wire dual_slope_pkg::request_t    request,
   output logic                             busy,
   output logic                             done,
   output dual_slope_pkg::result_t          result,
   output logic                             first_step_line,
   output logic                             second_step_line,
   output logic                             chan_sel_msb,
   output logic                             chan_sel_lsb,
   input  wire logic                        comparator_out
);
   localparam int W = dual_slope_pkg::COUNT_W;

   dual_slope_pkg::phase_t         phase;
   dual_slope_pkg::phase_t         next_phase;
   logic [W-1:0]                   count;
   logic [1:0]                     step;
   logic [1:0]                     channel;
   logic                           use_zero;
   logic                           cmp_meta;
   logic                           cmp_sync;
   logic                           cmp_last;
   logic                           positive;
   logic                           overrange;

   wire cmp_changed   = cmp_sync != cmp_last;
   wire accum_end     = (phase == dual_slope_pkg::ST_ACCUM)
                        && (count == dual_slope_pkg::ACCUM_CYCLES);
   wire null_end      = (phase == dual_slope_pkg::ST_NULL)
                        && (count == dual_slope_pkg::NULL_CYCLES);
   wire rundown_stop  = (phase == dual_slope_pkg::ST_RUNDOWN) && cmp_changed;
   wire rundown_over  = (phase == dual_slope_pkg::ST_RUNDOWN) && !cmp_changed
                        && (count == dual_slope_pkg::RUNDOWN_MAX);
   wire rundown_end   = rundown_stop || rundown_over;
   wire zero_ok       = (phase == dual_slope_pkg::ST_ZERO) && cmp_sync;
   wire zero_over     = (phase == dual_slope_pkg::ST_ZERO) && !cmp_sync
                        && (count == dual_slope_pkg::ZERO_MAX);
   wire zero_end      = zero_ok || zero_over;
   wire cycle_end     = (rundown_end && !use_zero) || zero_end;
   wire phase_change  = (next_phase != phase);

   // phase to step line code
   always_comb
   begin
      case (phase)
         dual_slope_pkg::ST_NULL:    step = dual_slope_pkg::STEP_NULL;
         dual_slope_pkg::ST_ACCUM:   step = dual_slope_pkg::STEP_ACCUM;
         dual_slope_pkg::ST_RUNDOWN: step = dual_slope_pkg::STEP_RUNDOWN;
         dual_slope_pkg::ST_ZERO:    step = dual_slope_pkg::STEP_ZERO;
         default:                    step = dual_slope_pkg::STEP_NULL;
      endcase
   end

   // fixed phase order; idle parks in offset null
   always_comb
   begin
      next_phase = phase;
      case (phase)
         dual_slope_pkg::ST_IDLE:
            if (start)
               next_phase = dual_slope_pkg::ST_NULL;
         dual_slope_pkg::ST_NULL:
            if (null_end)
               next_phase = dual_slope_pkg::ST_ACCUM;
         dual_slope_pkg::ST_ACCUM:
            if (accum_end)
               next_phase = dual_slope_pkg::ST_RUNDOWN;
         dual_slope_pkg::ST_RUNDOWN:
            if (rundown_end)
               next_phase = use_zero ? dual_slope_pkg::ST_ZERO
                                     : dual_slope_pkg::ST_IDLE;
         dual_slope_pkg::ST_ZERO:
            if (zero_end)
               next_phase = dual_slope_pkg::ST_IDLE;
         default:
            next_phase = dual_slope_pkg::ST_IDLE;
      endcase
   end

   // comparator synchroniser
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         cmp_last <= 1'b0;
      end
      else if (enable)
      begin
         cmp_meta <= comparator_out;
         cmp_sync <= cmp_meta;
         cmp_last <= cmp_sync;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         phase <= dual_slope_pkg::ST_IDLE;
         count <= dual_slope_pkg::COUNT_ZERO;
      end
      else if (enable)
      begin
         phase <= next_phase;
         // counter restarts at each phase entry
         count <= phase_change ? dual_slope_pkg::COUNT_ONE
                               : count + dual_slope_pkg::COUNT_ONE;
      end
   end

   // request capture and held pin drive
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         channel  <= 2'h0;
         use_zero <= 1'b1;
      end
      else if (enable && phase == dual_slope_pkg::ST_IDLE && start)
      begin
         channel  <= request.channel;
         use_zero <= request.use_zero;
      end
   end

   // comparator only read in accumulate and later phases
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         positive  <= 1'b0;
         overrange <= 1'b0;
      end
      else if (enable)
      begin
         if (accum_end)
            positive <= cmp_sync;
         if (null_end)
            overrange <= 1'b0;
         else if (rundown_over || zero_over)
            overrange <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         first_step_line  <= 1'b0;
         second_step_line <= 1'b1;
         done             <= 1'b0;
         result           <= '0;
      end
      else if (enable)
      begin
         first_step_line  <= step[1];
         second_step_line <= step[0];
         done             <= cycle_end;
         if (rundown_end)
            result.rundown_period <= count;
         if (cycle_end)
         begin
            result.positive  <= positive;
            result.overrange <= overrange || rundown_over || zero_over;
            result.channel   <= channel;
         end
      end
      else
         done <= 1'b0;
   end

   assign chan_sel_msb = channel[1];
   assign chan_sel_lsb = channel[0];
   assign busy         = (phase != dual_slope_pkg::ST_IDLE);

   // the device's reference polarity and zero crossing are its own

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // named steps of a conversion, shared by the checks below
   sequence s_null_leave;
      enable && null_end;
   endsequence
   sequence s_accum_leave;
      enable && accum_end;
   endsequence
   sequence s_rundown_hit;
      enable && rundown_stop;
   endsequence
   sequence s_rundown_timeout;
      enable && rundown_over;
   endsequence
   sequence s_zero_seen;
      enable && zero_ok;
   endsequence
   sequence s_zero_timeout;
      enable && zero_over;
   endsequence

   // phase order and phase lengths
   a_accum_length: assert property
      ((phase == dual_slope_pkg::ST_ACCUM)
       && (count < dual_slope_pkg::ACCUM_CYCLES)
       |=> phase == dual_slope_pkg::ST_ACCUM)
      else $error("accumulate phase left early");
   a_accum_next: assert property
      (s_accum_leave |=> phase == dual_slope_pkg::ST_RUNDOWN)
      else $error("rundown did not follow accumulate");
   a_null_next: assert property
      (s_null_leave |=> phase == dual_slope_pkg::ST_ACCUM)
      else $error("accumulate did not follow offset null");
   a_rundown_held: assert property
      ((phase == dual_slope_pkg::ST_RUNDOWN) && !cmp_changed && !rundown_over
       |=> phase == dual_slope_pkg::ST_RUNDOWN)
      else $error("rundown ended without comparator change");
   a_rundown_zero: assert property
      (s_rundown_hit ##0 use_zero |=> phase == dual_slope_pkg::ST_ZERO)
      else $error("output zero did not follow rundown");
   a_rundown_skip: assert property
      (s_rundown_hit ##0 !use_zero |=> phase == dual_slope_pkg::ST_IDLE)
      else $error("short cycle did not end after rundown");
   a_zero_exit: assert property
      (s_zero_seen |=> phase == dual_slope_pkg::ST_IDLE)
      else $error("output zero not ended on comparator high");
   a_zero_held: assert property
      ((phase == dual_slope_pkg::ST_ZERO) && !cmp_sync && !zero_over
       |=> phase == dual_slope_pkg::ST_ZERO)
      else $error("output zero ended with comparator low");

   // rundown timing and result
   a_count_start: assert property
      (s_accum_leave |=> count == dual_slope_pkg::COUNT_ONE)
      else $error("rundown counter not restarted");
   a_count_latch: assert property
      (enable && rundown_end |=> result.rundown_period == $past(count))
      else $error("rundown count not taken as result");
   a_polarity_take: assert property
      (s_accum_leave |=> positive == $past(cmp_sync))
      else $error("polarity not sampled");
   a_overrange_flag: assert property
      (s_rundown_timeout |=> overrange)
      else $error("overrange not flagged");
   a_zero_bound: assert property
      (s_zero_timeout |=> phase == dual_slope_pkg::ST_IDLE && result.overrange)
      else $error("output zero timeout not flagged");
   a_done_pulse: assert property
      (done |=> !done)
      else $error("done stood for more than one cycle");

   // step line codes follow the phase one cycle late
   a_null_code: assert property
      (enable && (phase == dual_slope_pkg::ST_NULL) |=>
       (!first_step_line && second_step_line))
      else $error("wrong offset null code");
   a_accum_code: assert property
      (enable && (phase == dual_slope_pkg::ST_ACCUM) |=>
       (first_step_line && !second_step_line))
      else $error("wrong accumulate code");
   a_rundown_code: assert property
      (enable && (phase == dual_slope_pkg::ST_RUNDOWN) |=>
       (first_step_line && second_step_line))
      else $error("wrong rundown code");
   a_zero_code: assert property
      (enable && (phase == dual_slope_pkg::ST_ZERO) |=>
       (!first_step_line && !second_step_line))
      else $error("wrong output zero code");

   // pins stay put while a phase or a conversion lasts
   a_lines_steady: assert property
      (enable && !phase_change |=> ##1
       $stable({first_step_line, second_step_line}))
      else $error("step lines moved inside a phase");
   a_channel_hold: assert property
      (busy |=> $stable({chan_sel_msb, chan_sel_lsb}))
      else $error("channel lines moved during a conversion");
endmodule
`default_nettype wire

// *** verification/converter_front_model.sv ***
/*
 behavioural converter front end: decodes the step and channel lines and
 answers on comparator_out. assumes the bench sets polarity and ramp times.
*/
`timescale 1ns/1ps
`default_nettype none
module converter_front_model
(
   input  wire logic        clock,
   input  wire logic        first_step_line,
   input  wire logic        second_step_line,
   input  wire logic        chan_sel_msb,
   input  wire logic        chan_sel_lsb,
   input  wire logic        positive_in,
   input  wire logic [15:0] ramp_len,
   input  wire logic [15:0] zero_len,
   output logic      [2:0]  routed_channel,
   output logic             comparator_out
);
   logic [1:0]  code;
   logic [1:0]  last = 2'h1;
   logic [15:0] age = 16'h0000;
   logic        odd = 1'b0;
   wire         same = (code == last);
   assign code = {first_step_line, second_step_line};
   assign routed_channel = {1'b0, chan_sel_msb, chan_sel_lsb} + 3'h1;
   always @(posedge clock)
   begin
      odd <= ~odd;
      last <= code;
      age <= same ? age + 16'h0001 : 16'h0001;
      case (code)
         2'h1: comparator_out <= odd; // undefined here
         2'h2: comparator_out <= positive_in;
         2'h3: comparator_out <= (same && age >= ramp_len) ^ positive_in;
         default: comparator_out <= same && age >= zero_len;
      endcase
   end
endmodule
`default_nettype wire

// *** verification/dual_slope_phase_sequencer_tb_top.sv ***
/*
 self-checking bench for the phase sequencer driving a converter model.
 assumes the fixed package timing, so each conversion runs long.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) \
begin n_errors++; $display("wrong value %s expected %h seen %h", what, \
exp, got); end end
module dual_slope_phase_sequencer_tb_top;
   logic                     clock = 1'b0;
   logic                     reset_n = 1'b0;
   logic                     enable = 1'b1;
   logic                     start = 1'b0;
   logic                     pos = 1'b1;
   dual_slope_pkg::request_t request = '0;
   dual_slope_pkg::result_t  result;
   logic                     busy, done, a_line, b_line, msb, lsb, cmp;
   logic [2:0]               routed;
   logic [1:0]               seen = 2'h1;
   logic [15:0]              ramp = 16'h00c8;
   logic [1:0]               codes[$];
   int                       lens[$];
   int                       run = 0;
   int                       n_errors = 0;
   int                       check_count = 0;
   int                       cycles = 0;

   dual_slope_phase_sequencer u_dut
   (
      .clock            (clock),
      .reset_n          (reset_n),
      .enable           (enable),
      .start            (start),
      .request          (request),
      .busy             (busy),
      .done             (done),
      .result           (result),
      .first_step_line  (a_line),
      .second_step_line (b_line),
      .chan_sel_msb     (msb),
      .chan_sel_lsb     (lsb),
      .comparator_out   (cmp)
   );
   converter_front_model u_model
   (
      .clock            (clock),
      .first_step_line  (a_line),
      .second_step_line (b_line),
      .chan_sel_msb     (msb),
      .chan_sel_lsb     (lsb),
      .positive_in      (pos),
      .ramp_len         (ramp),
      .zero_len         (16'h001e),
      .routed_channel   (routed),
      .comparator_out   (cmp)
   );

   always #10 clock = ~clock;

   // record each run of a step line code and its length
   always @(negedge clock)
   begin
      if ({a_line, b_line} != seen)
      begin
         codes.push_back(seen);
         lens.push_back(run);
         run = 0;
      end
      run++;
      seen = {a_line, b_line};
      cycles++;
      if (cycles == 40000)
      begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic do_reset();
      reset_n = 1'b0;
      repeat (5) @(negedge clock);
      `CHK("lines", dual_slope_pkg::STEP_NULL, {a_line, b_line})
      `CHK("route", 3'h1, routed)
      `CHK("idle", 2'h0, {busy, done})
      reset_n = 1'b1;
   endtask

   // start on the last channel, freeze, then abort by reset
   task automatic abort_run();
      request = '{channel: 2'h3, use_zero: 1'b1};
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      enable = 1'b0;
      repeat (20) @(negedge clock);
      `CHK("frozen", 3'h5, {busy, a_line, b_line})
      `CHK("route", 3'h4, routed)
      enable = 1'b1;
      do_reset();
   endtask

   task automatic convert(input logic [1:0] ch, input logic zero,
                          input logic p);
      int k;
      pos = p;
      request = '{channel: ch, use_zero: zero};
      start = 1'b1;
      @(negedge clock);
      codes.delete();
      lens.delete();
      request.channel = ~ch;
      repeat (3) @(negedge clock);
      start = 1'b0;
      `CHK("busy", 1'b1, busy)
      `CHK("route", {1'b0, ch} + 3'h1, routed)
      for (k = 0; k < 20000 && done !== 1'b1; k++)
         @(negedge clock);
      `CHK("sign", p, result.positive)
      `CHK("over", 1'b0, result.overrange)
      `CHK("chan", ch, result.channel)
      @(negedge clock);
      `CHK("pulse", 1'b0, done)
      repeat (4) @(negedge clock);
      `CHK("steps", 3 + zero, codes.size())
      `CHK("seq", 6'h1b, {codes[0], codes[1], codes[2]})
      `CHK("null", 1'b1, lens[0] >= dual_slope_pkg::NULL_CYCLES)
      `CHK("accum", dual_slope_pkg::ACCUM_CYCLES, 24'(lens[1]))
      `CHK("ramp", 1'b1, lens[2] >= 200 && lens[2] <= 208)
      `CHK("count", 1'b1, result.rundown_period + 24'h2 - 24'(lens[2]) <= 24'h4)
      if (zero)
      begin
         `CHK("zero", dual_slope_pkg::STEP_ZERO, codes[3])
         `CHK("hold", 1'b1, lens[3] >= 30 && lens[3] <= 38)
      end
      `CHK("back", dual_slope_pkg::STEP_NULL, seen)
      `CHK("free", 1'b0, busy)
   endtask

   // a ramp that never crosses zero must end on the rundown bound
   task automatic over_run();
      int k;
      ramp = 16'hffff;
      pos = 1'b1;
      request = '{channel: 2'h0, use_zero: 1'b1};
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      for (k = 0; k < 20000 && done !== 1'b1; k++)
         @(negedge clock);
      `CHK("over", 1'b1, result.overrange)
      `CHK("max", dual_slope_pkg::RUNDOWN_MAX, result.rundown_period)
      `CHK("chan", 2'h0, result.channel)
      ramp = 16'h00c8;
      @(negedge clock);
   endtask

   initial
   begin
      do_reset();
      @(negedge clock);
      abort_run();
      convert(2'h1, 1'b1, 1'b1);
      over_run();
      convert(2'h2, 1'b0, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
